// ---- rtl/svm_pkg.sv ----
// Purpose: shared constants and types for the supply voltage monitor control
// Assumes: two detector channels, 8-bit register port
// Notes: register offsets are byte addresses on the plain register port
package svm_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [1:0] ADDR_LEVEL_FLAG = 2'h0; // detector_level_flag_reg
  localparam logic [1:0] ADDR_MODE_EN = 2'h1; // detector_mode_enable_reg

  // ****************************************
  // level/flag register fields
  // ****************************************
  localparam int LVL1_LO = 0; // channel 1 level select, two bits
  localparam int LVL2_LO = 2; // channel 2 level select, two bits
  localparam int SF1_BIT = 4; // channel 1 live status
  localparam int F1_BIT = 5; // channel 1 sticky flag
  localparam int SF2_BIT = 6; // channel 2 live status
  localparam int F2_BIT = 7; // channel 2 sticky flag

  // ****************************************
  // mode/enable register fields
  // ****************************************
  localparam int EN1_BIT = 0; // channel 1 enable
  localparam int MOD1_BIT = 1; // channel 1 action select
  localparam int EN2_BIT = 2; // channel 2 enable
  localparam int MOD2_BIT = 3; // channel 2 action select
  localparam logic [7:0] MODE_EN_WMASK = 8'h3f; // bits 7:6 read zero

  // ****************************************
  // reset values and level codes
  // ****************************************
  localparam logic [1:0] LEVEL_RESET = 2'h0; // level reset value
  localparam logic [7:0] MODE_EN_RESET = 8'h00; // mode/enable reset value
  localparam logic [1:0] LVL_4V50 = 2'h0; // 4.50 V
  localparam logic [1:0] LVL_4V20 = 2'h1; // 4.20 V
  localparam logic [1:0] LVL_3V70 = 2'h2; // 3.70 V
  localparam logic [1:0] LVL_3V15 = 2'h3; // 3.15 V

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [1:0] addr; // register address
    logic [7:0] wdata; // write data
    logic wr; // write strobe
    logic rd; // read strobe
  } svm_bus_req_t;

  typedef struct packed {
    logic [1:0] level; // threshold selection
    logic enable; // channel enable
    logic action; // 0 interrupt, 1 reset
  } svm_chan_cfg_t;

endpackage

// ---- rtl/svm_channel.sv ----
// Purpose: one detector channel: synchroniser, live status and sticky flag
// Assumes: comparator output is asynchronous to clk, high when supply is low
// Notes: sticky flag set wins over software clear
`timescale 1ns/1ps
module svm_channel (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration
  input svm_pkg::svm_chan_cfg_t cfg,
  // comparator input from analog side
  input wire logic below_async,
  // software clear of the sticky flag
  input wire logic flag_clear,
  // results
  output logic live_below_status,
  output logic sticky_below_flag,
  output logic below_now
);

  // ****************************************
  // synchroniser
  // ****************************************
  logic sync1_q; // first stage, read only by second stage
  logic sync2_q; // second stage
  logic flag_q; // sticky flag
  logic flag_d; // next sticky flag

  // two flops on the comparator output
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= below_async;
      sync2_q <= sync1_q;
    end
  end

  // live status follows the comparator while enabled, no holding
  assign below_now = cfg.enable & sync2_q;
  assign live_below_status = below_now;

  // set beats clear; disabling does not clear
  assign flag_d = below_now ? 1'b1 : (flag_clear ? 1'b0 : flag_q);

  // sticky flag register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign sticky_below_flag = flag_q;

endmodule // svm_channel

// ---- rtl/svm_ctrl.sv ----
// Purpose: control registers and request logic of a two-channel supply monitor
// Assumes: reset is power-on or external reset only; detection reset is an output
// Notes: registers sit on a plain strobe port with read data one cycle later
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module svm_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // analog side
  input wire logic [1:0] below_async,
  output logic [1:0] level_sel_1_0,
  output logic [1:0] level_sel_2,
  output logic [1:0] comp_enable,
  // requests
  output logic supply_low_irq,
  output logic detect_reset
);

  // ****************************************
  // registers
  // ****************************************
  logic [1:0] lvl1_q; // channel 1 level
  logic [1:0] lvl2_q; // channel 2 level
  logic [7:0] mode_en_q; // mode/enable register
  logic [7:0] rdata_q; // read data
  logic irq_q; // interrupt request pulse
  logic rst_q; // detection reset level
  logic [1:0] below_prev_q; // previous gated comparator, for edges
  logic [1:0] lvl_en_q; // comparator enable outputs
  logic [3:0] lvl_out_q; // level outputs

  // ****************************************
  // decode
  // ****************************************
  svm_pkg::svm_bus_req_t req; // bundled request
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  wire wr_lf = req.wr && (req.addr == svm_pkg::ADDR_LEVEL_FLAG);
  wire wr_me = req.wr && (req.addr == svm_pkg::ADDR_MODE_EN);
  wire rd_lf = req.rd && (req.addr == svm_pkg::ADDR_LEVEL_FLAG);
  wire rd_me = req.rd && (req.addr == svm_pkg::ADDR_MODE_EN);

  // per-channel configuration
  svm_pkg::svm_chan_cfg_t cfg1;
  svm_pkg::svm_chan_cfg_t cfg2;
  assign cfg1 = '{level: lvl1_q, enable: mode_en_q[svm_pkg::EN1_BIT], action: mode_en_q[svm_pkg::MOD1_BIT]};
  assign cfg2 = '{level: lvl2_q, enable: mode_en_q[svm_pkg::EN2_BIT], action: mode_en_q[svm_pkg::MOD2_BIT]};

  // software writes 0 to a sticky flag to clear it; 1 is ignored
  wire clr1 = wr_lf && !req.wdata[svm_pkg::F1_BIT];
  wire clr2 = wr_lf && !req.wdata[svm_pkg::F2_BIT];

  // ****************************************
  // channels
  // ****************************************
  wire [1:0] sf; // live status
  wire [1:0] ff; // sticky flags
  wire [1:0] bn; // gated below

  svm_channel u_ch1 (
    .clk(clk),
    .reset(reset),
    .cfg(cfg1),
    .below_async(below_async[0]),
    .flag_clear(clr1),
    .live_below_status(sf[0]),
    .sticky_below_flag(ff[0]),
    .below_now(bn[0])
  );

  svm_channel u_ch2 (
    .clk(clk),
    .reset(reset),
    .cfg(cfg2),
    .below_async(below_async[1]),
    .flag_clear(clr2),
    .live_below_status(sf[1]),
    .sticky_below_flag(ff[1]),
    .below_now(bn[1])
  );

  // ****************************************
  // request logic
  // ****************************************
  wire [1:0] act = {cfg2.action, cfg1.action};
  // interrupt on any change of the gated comparator in interrupt mode; disabling while low
  // also makes a change, which is the spurious request software must mask
  wire [1:0] edge_any = bn ^ below_prev_q;
  wire irq_d = |(edge_any & ~act);
  // reset level held while low in reset mode, reasserts at once
  wire rst_d = |(bn & act);

  // ****************************************
  // read mux
  // ****************************************
  wire [7:0] lf_val = {ff[1], sf[1], ff[0], sf[0], lvl2_q, lvl1_q};
  wire [7:0] rd_d = rd_lf ? lf_val : (rd_me ? mode_en_q : 8'h00);

  // configuration registers, cleared only by the system reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lvl1_q <= svm_pkg::LEVEL_RESET;
      lvl2_q <= svm_pkg::LEVEL_RESET;
      mode_en_q <= svm_pkg::MODE_EN_RESET;
    end else begin
      if (wr_lf) begin
        lvl1_q <= req.wdata[svm_pkg::LVL1_LO +: 2];
        lvl2_q <= req.wdata[svm_pkg::LVL2_LO +: 2];
      end
      if (wr_me) begin
        mode_en_q <= req.wdata & svm_pkg::MODE_EN_WMASK;
      end
    end
  end

  // outputs and history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      rst_q <= 1'b0;
      below_prev_q <= 2'h0;
      lvl_en_q <= 2'h0;
      lvl_out_q <= 4'h0;
    end else begin
      rdata_q <= rd_d;
      irq_q <= irq_d;
      rst_q <= rst_d;
      below_prev_q <= bn;
      lvl_en_q <= {cfg2.enable, cfg1.enable};
      lvl_out_q <= {lvl2_q, lvl1_q};
    end
  end

  assign rdata = rdata_q;
  assign supply_low_irq = irq_q;
  assign detect_reset = rst_q;
  assign comp_enable = lvl_en_q;
  assign level_sel_1_0 = lvl_out_q[1:0];
  assign level_sel_2 = lvl_out_q[3:2];

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_reset_tracks_low: assert property (bn[0] && act[0] |=> detect_reset)
    else $error("detection reset not asserted while low");
  a_no_reset_irqmode: assert property (!(|(bn & act)) |=> !detect_reset)
    else $error("detection reset without reset-mode channel");
  a_irq_on_fall: assert property ($rose(bn[0]) && !act[0] |=> supply_low_irq)
    else $error("missing interrupt on low");
  a_flag_sticks: assert property (ff[0] && !clr1 |=> ff[0])
    else $error("sticky flag dropped");
  a_flag_set_wins: assert property (bn[0] && clr1 |=> ff[0])
    else $error("clear beat detection");
  a_status_off: assert property (!cfg1.enable |-> !sf[0])
    else $error("status set while disabled");
  a_sync_delay: assert property (cfg1.enable && $stable(cfg1.enable) && below_async[0] [*3] |-> sf[0])
    else $error("status not following comparator");
  a_enable_write: assert property (wr_me |=> mode_en_q[svm_pkg::EN1_BIT] == $past(wdata[svm_pkg::EN1_BIT]))
    else $error("enable write lost");
  a_level_hold: assert property (!wr_lf |=> $stable(lvl1_q))
    else $error("level changed without write");
  a_mode_hold: assert property (!wr_me |=> $stable(mode_en_q))
    else $error("mode register changed without write");
  a_irq_on_rise: assert property ($fell(bn[0]) && !act[0] |=> supply_low_irq)
    else $error("missing interrupt on recovery or disable");
  a_irq_one_cycle: assert property (supply_low_irq && $stable(bn) |=> !supply_low_irq)
    else $error("interrupt pulse longer than one cycle");
  a_enable_out: assert property (cfg2.enable |=> comp_enable[1])
    else $error("channel 2 comparator enable not driven");
  a_level_out: assert property (lvl2_q == svm_pkg::LVL_3V15 |=> level_sel_2 == svm_pkg::LVL_3V15)
    else $error("channel 2 level output wrong");

  // ****************************************
  // channel 2 checks
  // ****************************************
  a_reset_tracks_ch2: assert property (bn[1] && act[1] |=> detect_reset)
    else $error("detection reset not asserted while channel 2 low");
  a_flag2_sticks: assert property (ff[1] && !clr2 |=> ff[1])
    else $error("channel 2 sticky flag dropped");
  a_flag2_set_wins: assert property (bn[1] && clr2 |=> ff[1])
    else $error("channel 2 clear beat detection");
  a_status2_off: assert property (!cfg2.enable |-> !sf[1])
    else $error("channel 2 status set while disabled");

  // ****************************************
  // re-assertion after a detection reset ends
  // ****************************************
  // detection reset was high and has just dropped
  sequence s_rst_ended;
    detect_reset ##1 !detect_reset;
  endsequence
  // channel 1 armed for reset sees a low supply again
  sequence s_low_again;
    bn[0] && act[0];
  endsequence
  a_reassert_low: assert property (s_rst_ended ##[1:8] s_low_again |=> detect_reset)
    else $error("detection reset not reasserted at once");

endmodule // svm_ctrl

// ---- test/tb_svm_ctrl.sv ----
// Purpose: self-checking bench for the two-channel supply monitor control
// Assumes: comparator inputs are driven directly by the bench
// Notes: settle waits after comparator changes cover the two-flop synchroniser
`timescale 1ns/1ps
module tb_svm_ctrl;
  // ********************
  // bench signals
  // ********************
  logic clk = 1'b0; // system clock
  logic reset = 1'b1; // async reset
  logic [1:0] addr = 2'h0; // register address
  logic [7:0] wdata = 8'h00; // write data
  logic wr = 1'b0; // write strobe
  logic rd = 1'b0; // read strobe
  logic [7:0] rdata; // read data
  logic [1:0] below = 2'h0; // comparator outputs, high means low supply
  logic [1:0] lvl1; // channel 1 level to analog
  logic [1:0] lvl2; // channel 2 level to analog
  logic [1:0] cen; // comparator enables
  logic irq; // interrupt request pulse
  logic rst_out; // detection reset
  int bad_count = 0; // mismatches
  int checks = 0; // comparisons
  int irq_n = 0; // interrupt pulses seen
  int base; // irq count snapshot
  localparam int SETTLE_CYC = 200; // detector settling wait, 5 us at 25 ns

  // clock at 40 MHz
  always #12.5 clk = ~clk;

  svm_ctrl dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .below_async(below), .level_sel_1_0(lvl1), .level_sel_2(lvl2),
    .comp_enable(cen), .supply_low_irq(irq), .detect_reset(rst_out));

  // count one-cycle interrupt pulses
  always @(posedge clk) begin
    if (irq === 1'b1) irq_n <= irq_n + 1;
  end

  // ********************
  // helper tasks
  // ********************
  // compare one byte-sized result
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one-cycle register write
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // one-cycle read, data judged in the following cycle
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk8(rdata, exp, what);
  endtask
  // change comparators and let the synchroniser settle
  task automatic set_below(input logic [1:0] v);
    @(posedge clk);
    below <= v;
    repeat (6) @(posedge clk);
    #1;
  endtask

  // ********************
  // scenarios
  // ********************
  // reset values, unmapped read, idle outputs
  task automatic t_reset();
    rd_chk(2'h0, 8'h00, "level reg reset");
    rd_chk(2'h1, 8'h00, "mode reg reset");
    rd_chk(2'h2, 8'h00, "unmapped read");
    chk8({lvl1, lvl2, cen, irq, rst_out}, 8'h00, "outputs idle");
  endtask
  // every level code on both channels
  task automatic t_levels();
    for (int i = 0; i < 4; i++) begin
      wr_reg(2'h0, {4'h0, 2'(i), 2'(3 - i)});
      chk8({4'h0, lvl2, lvl1}, {4'h0, 2'(i), 2'(3 - i)}, "level outputs");
      rd_chk(2'h0, {4'h0, 2'(i), 2'(3 - i)}, "level readback");
    end
    wr_reg(2'h0, 8'h00);
  endtask
  // interrupt mode on channel 1, live and sticky flags
  task automatic t_irq();
    wr_reg(2'h0, 8'h00);
    wr_reg(2'h1, 8'h01);
    chk8({6'h0, cen}, 8'h01, "enable out");
    repeat (SETTLE_CYC) @(posedge clk);
    rd_chk(2'h0, 8'h00, "flags quiet");
    base = irq_n;
    set_below(2'h1);
    rd_chk(2'h0, 8'h30, "live and sticky set");
    chk8(8'(irq_n - base), 8'h01, "irq on fall");
    set_below(2'h0);
    rd_chk(2'h0, 8'h20, "sticky holds");
    chk8(8'(irq_n - base), 8'h02, "irq on rise");
    chk8({7'h0, rst_out}, 8'h00, "no reset in irq mode");
    set_below(2'h1);
    wr_reg(2'h1, 8'h00);
    rd_chk(2'h0, 8'h20, "sticky after disable");
    chk8(8'(irq_n - base), 8'h04, "spurious irq on disable");
    set_below(2'h0);
    wr_reg(2'h0, 8'h00);
    rd_chk(2'h0, 8'h00, "sticky cleared");
    wr_reg(2'h0, 8'hf0);
    rd_chk(2'h0, 8'h00, "flags not settable");
  endtask
  // reset mode on channel 1, hold and re-assert
  task automatic t_rstmode();
    wr_reg(2'h0, 8'h00);
    wr_reg(2'h1, 8'h01);
    repeat (SETTLE_CYC) @(posedge clk);
    rd_chk(2'h0, 8'h00, "status clear before arming");
    wr_reg(2'h0, 8'h00);
    wr_reg(2'h1, 8'h03);
    base = irq_n;
    set_below(2'h1);
    for (int i = 0; i < 10; i++) begin
      chk8({7'h0, rst_out}, 8'h01, "reset held");
      @(posedge clk);
      #1;
    end
    chk8(8'(irq_n - base), 8'h00, "no irq in reset mode");
    rd_chk(2'h1, 8'h03, "mode reg kept");
    set_below(2'h0);
    chk8({7'h0, rst_out}, 8'h00, "reset released");
    @(posedge clk);
    below <= 2'h1;
    repeat (4) @(posedge clk);
    #1;
    chk8({7'h0, rst_out}, 8'h01, "reset again at once");
    wr_reg(2'h1, 8'h01);
    chk8({7'h0, rst_out}, 8'h00, "mode cleared drops reset");
    set_below(2'h0);
    wr_reg(2'h1, 8'h00);
  endtask
  // channel 2 in interrupt mode, then in reset mode
  task automatic t_ch2();
    wr_reg(2'h0, 8'h00);
    wr_reg(2'h1, 8'h04);
    base = irq_n;
    set_below(2'h2);
    set_below(2'h0);
    chk8(8'(irq_n - base), 8'h02, "ch2 irq both edges");
    repeat (SETTLE_CYC) @(posedge clk);
    rd_chk(2'h0, 8'h80, "ch2 status clear, sticky set");
    wr_reg(2'h0, 8'h00);
    wr_reg(2'h1, 8'h0c);
    chk8({6'h0, cen}, 8'h02, "enable out ch2");
    base = irq_n;
    set_below(2'h2);
    chk8({7'h0, rst_out}, 8'h01, "reset ch2");
    rd_chk(2'h0, 8'hc0, "ch2 flags");
    chk8(8'(irq_n - base), 8'h00, "no irq in reset mode ch2");
    set_below(2'h0);
    wr_reg(2'h1, 8'h04);
    wr_reg(2'h1, 8'h00);
    wr_reg(2'h0, 8'h00);
  endtask
  // disabled channels ignore a low supply
  task automatic t_off();
    set_below(2'h3);
    rd_chk(2'h0, 8'h00, "disabled no flags");
    chk8({7'h0, rst_out}, 8'h00, "disabled no reset");
    set_below(2'h0);
  endtask
  // system reset in mid-run clears both registers
  task automatic t_sysreset();
    wr_reg(2'h1, 8'h05);
    wr_reg(2'h0, 8'h0f);
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd_chk(2'h0, 8'h00, "level reg after reset");
    rd_chk(2'h1, 8'h00, "mode reg after reset");
    chk8({lvl1, lvl2, cen, irq, rst_out}, 8'h00, "outputs after reset");
  endtask

  // ********************
  // verdict
  // ********************
  task automatic close_out();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_levels();
    t_irq();
    t_rstmode();
    t_ch2();
    t_off();
    t_sysreset();
    close_out();
  end

  // watchdog well beyond the expected run
  initial begin
    #(20000 * 25);
    bad_count++;
    close_out();
  end
endmodule // tb_svm_ctrl
